// ==== common/rcsw_pkg.sv ====
// Constants and types for the sleep, wake-up and reset-cause block
package rcsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: times in their own units, counts derived from the clock period
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WDT_TIMEOUT_NS = 18000000;
  localparam int unsigned WDT_CYCLES =
    (WDT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRT_POR_NS = 1125000;
  localparam int unsigned DRT_POR_CYCLES =
    (DRT_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRT_SUB_NS = 10000;
  localparam int unsigned DRT_SUB_CYCLES =
    (DRT_SUB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_W = 4;
  localparam int CMP_W = 2;
  localparam int INT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PORT = 8'h0c;
  localparam logic [7:0] OFS_CMP = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;

  // Control fields and reset value
  localparam int CTRL_WDT_EN = 0;
  localparam int CTRL_EXT_RST_EN = 1;
  localparam int CTRL_PIN_WAKE_EN = 2;
  localparam int CTRL_CMP_WAKE_EN = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;

  // Command fields
  localparam int CMD_SLEEP = 0;
  localparam int CMD_CLR_WDT = 1;

  // Flag register fields
  localparam int FLAG_PIN_WAKE = 7;
  localparam int FLAG_CMP_WAKE = 6;
  localparam int FLAG_TIME_OUT = 4;
  localparam int FLAG_POWER_DOWN = 3;

  // Interrupt event fields
  localparam int INT_WAKE = 0;
  localparam int INT_WDT = 1;
  localparam int INT_EXT = 2;
  localparam int INT_SLEEP = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum {ST_RESET, ST_RUN, ST_SLEEP} rcsw_state_t;
  typedef enum {CAUSE_NONE, CAUSE_EXT, CAUSE_WDT, CAUSE_PIN, CAUSE_CMP}
    rcsw_cause_t;

  typedef struct packed {
    logic [PIN_W-1:0] level;
    logic [PIN_W-1:0] oe;
  } rcsw_pad_t;

  typedef struct packed {
    logic pin_wake_flag;
    logic comparator_wake_flag;
    logic time_out_flag;
    logic power_down_flag;
  } rcsw_flags_t;

endpackage : rcsw_pkg

// ==== design/rcsw_top.sv ====
// Sleep entry, wake-up and reset-cause recording block
//
// Notes on behaviour
// R01: Sleep clears watchdog, sets time-out flag, clears power-down, stops osc.
// R02: Port pins keep their pre-sleep drive state throughout sleep.
// R03: Watchdog reset never drives the external reset pin low.
// R04: Sleep ends in reset on ext pin, watchdog, pin or comparator change.
// R05: Watchdog time-out causing reset clears the time-out flag.
// R06: Power-down flag set at power-up, cleared by every sleep.
// R07: Comparator change during sleep sets the comparator wake flag.
// R08: Monitored pin change during sleep sets the pin wake flag.
// R09: Pin change compares with values captured at the last port read.
// R10: Comparator change compares with values seen at last comparator read.
// R11: Watchdog counter cleared on every wake-up, whatever the cause.
// R12: Watchdog wake from sleep leaves all four flags at zero.
// R13: Watchdog reset outside sleep: wakes, time-out zero; power-down kept.
// R14: Ext pin wake: wake flags zero, time-out one, power-down zero.
// R15: Pin or comparator wake sets its flag, time-out one, power-down zero.
// R16: Ext pin reset while awake clears wake flags, keeps the others.
// R17: Watchdog wake from sleep runs the reset timer, holding the core.
`timescale 1ns/1ps
module rcsw_top
  import rcsw_pkg::*;
#(
  parameter int unsigned WDT_CYCLES_P = WDT_CYCLES,
  parameter int unsigned DRT_POR_P = DRT_POR_CYCLES
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Pins from outside
  input wire logic external_reset_pin_n,
  input wire logic [PIN_W-1:0] mon_pins,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  // External reset pin drive side
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  // Port drive from the core and to the pads
  input wire rcsw_pad_t port_drive,
  output rcsw_pad_t port_pad,
  // Core control
  output logic cpu_reset,
  output logic osc_drive_en,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  rcsw_state_t state;
  rcsw_state_t next_state;
  rcsw_cause_t cause;
  rcsw_flags_t flags;
  logic [3:0] ctrl;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] next_int;
  logic [31:0] wdt_cnt;
  logic [31:0] drt_cnt;
  logic ext_meta;
  logic ext_n_s;
  logic [PIN_W-1:0] pins_meta;
  logic [PIN_W-1:0] pins_s;
  logic [CMP_W-1:0] cmp_meta;
  logic [CMP_W-1:0] cmp_s;
  logic [PIN_W-1:0] pin_snap;
  logic [CMP_W-1:0] cmp_snap;
  logic ext_assert;
  logic wdt_expire;
  logic pin_change;
  logic cmp_change;
  logic cmd_sleep;
  logic cmd_clr_wdt;

  // Any bit differs between live value and snapshot
  function automatic logic differs(input logic [PIN_W-1:0] a,
                                   input logic [PIN_W-1:0] b);
    differs = |(a ^ b);
  endfunction : differs

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage is read by the second only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_meta <= 1'b1;
      ext_n_s <= 1'b1;
      pins_meta <= '0;
      pins_s <= '0;
      cmp_meta <= '0;
      cmp_s <= '0;
    end else begin
      ext_meta <= external_reset_pin_n;
      ext_n_s <= ext_meta;
      pins_meta <= mon_pins;
      pins_s <= pins_meta;
      cmp_meta <= {comparator_two_output, comparator_one_output};
      cmp_s <= cmp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  assign ext_assert = ctrl[CTRL_EXT_RST_EN] & ~ext_n_s;
  assign wdt_expire = ctrl[CTRL_WDT_EN] & (wdt_cnt == WDT_CYCLES_P - 1);
  assign pin_change = ctrl[CTRL_PIN_WAKE_EN] & differs(pins_s, pin_snap); // R09
  assign cmp_change = ctrl[CTRL_CMP_WAKE_EN] &
    differs({2'b00, cmp_s}, {2'b00, cmp_snap}); // R10
  assign cmd_sleep = reg_wr & (reg_addr == OFS_CMD) & reg_wdata[CMD_SLEEP];
  assign cmd_clr_wdt = reg_wr & (reg_addr == OFS_CMD) &
    reg_wdata[CMD_CLR_WDT];

  ////////////////////////////////////////////////////////////////////////////
  // Next state and reset cause; pin reset outranks watchdog outranks wakes
  always_comb begin
    next_state = state;
    cause = CAUSE_NONE;
    case (state)
      ST_RESET: begin
        if (drt_cnt == 32'h0 && !ext_assert) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ext_assert) begin
          cause = CAUSE_EXT;
        end else if (wdt_expire) begin
          cause = CAUSE_WDT;
        end else if (cmd_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ext_assert) begin // R04
          cause = CAUSE_EXT;
        end else if (wdt_expire) begin // R04
          cause = CAUSE_WDT;
        end else if (pin_change) begin // R04
          cause = CAUSE_PIN;
        end else if (cmp_change) begin // R04
          cause = CAUSE_CMP;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    if (cause != CAUSE_NONE) begin
      next_state = ST_RESET;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset timer; reloads while the pin holds reset, so the delay
  // only starts once the pin is released
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drt_cnt <= DRT_POR_P;
    end else if (cause != CAUSE_NONE) begin
      drt_cnt <= DRT_SUB_CYCLES; // R17
    end else if (state == ST_RESET && ext_assert) begin
      drt_cnt <= DRT_SUB_CYCLES;
    end else if (state == ST_RESET && drt_cnt != 32'h0) begin
      drt_cnt <= drt_cnt - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter; keeps running through sleep when enabled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdt_cnt <= '0;
    end else if (cause != CAUSE_NONE) begin
      wdt_cnt <= '0; // R11
    end else if (state == ST_RUN && next_state == ST_SLEEP) begin
      wdt_cnt <= '0; // R01
    end else if (state == ST_RESET || cmd_clr_wdt) begin
      wdt_cnt <= '0;
    end else if (!ctrl[CTRL_WDT_EN]) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags <= '{1'b0, 1'b0, 1'b1, 1'b1}; // R06
    end else if (state == ST_RUN && next_state == ST_SLEEP) begin
      flags.time_out_flag <= 1'b1; // R01
      flags.power_down_flag <= 1'b0; // R06
    end else begin
      case (cause)
        CAUSE_EXT: begin
          flags.pin_wake_flag <= 1'b0; // R16
          flags.comparator_wake_flag <= 1'b0;
          if (state == ST_SLEEP) begin
            flags.time_out_flag <= 1'b1; // R14
            flags.power_down_flag <= 1'b0;
          end
        end
        CAUSE_WDT: begin
          flags.pin_wake_flag <= 1'b0; // R13
          flags.comparator_wake_flag <= 1'b0;
          flags.time_out_flag <= 1'b0; // R05
          if (state == ST_SLEEP) begin
            flags.power_down_flag <= 1'b0; // R12
          end
        end
        CAUSE_PIN: begin // R15
          flags <= '{1'b1, 1'b0, 1'b1, 1'b0}; // R08
        end
        CAUSE_CMP: begin
          flags <= '{1'b0, 1'b1, 1'b1, 1'b0}; // R07
        end
        default: begin
          flags <= flags;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshots taken by a read of the port or comparator register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_snap <= '0;
      cmp_snap <= '0;
    end else if (reg_rd && reg_addr == OFS_PORT) begin
      pin_snap <= pins_s; // R09
    end else if (reg_rd && reg_addr == OFS_CMP) begin
      cmp_snap <= cmp_s; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
      int_mask <= '0;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == OFS_INT_MASK) begin
      int_mask <= reg_wdata[INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: a new event wins over the clear by read
  always_comb begin
    next_int = int_stat;
    if (reg_rd && reg_addr == OFS_INT_STAT) begin
      next_int = '0;
    end
    next_int[INT_WAKE] = next_int[INT_WAKE] |
      (state == ST_SLEEP && cause != CAUSE_NONE);
    next_int[INT_WDT] = next_int[INT_WDT] | (cause == CAUSE_WDT);
    next_int[INT_EXT] = next_int[INT_EXT] | (cause == CAUSE_EXT);
    next_int[INT_SLEEP] = next_int[INT_SLEEP] |
      (state == ST_RUN && next_state == ST_SLEEP);
  end

  // Interrupt registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else begin
      int_stat <= next_int;
      irq <= |(next_int & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == OFS_CTRL) begin
      reg_rdata <= {4'h0, ctrl};
    end else if (reg_addr == OFS_FLAGS) begin
      reg_rdata <= '0;
      reg_rdata[FLAG_PIN_WAKE] <= flags.pin_wake_flag;
      reg_rdata[FLAG_CMP_WAKE] <= flags.comparator_wake_flag;
      reg_rdata[FLAG_TIME_OUT] <= flags.time_out_flag;
      reg_rdata[FLAG_POWER_DOWN] <= flags.power_down_flag;
    end else if (reg_addr == OFS_PORT) begin
      reg_rdata <= {4'h0, pins_s};
    end else if (reg_addr == OFS_CMP) begin
      reg_rdata <= {6'h00, cmp_s};
    end else if (reg_addr == OFS_INT_STAT) begin
      reg_rdata <= {4'h0, int_stat};
    end else if (reg_addr == OFS_INT_MASK) begin
      reg_rdata <= {4'h0, int_mask};
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core controls, pad hold and the reset pin, which is never pulled low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_reset <= 1'b1;
      osc_drive_en <= 1'b1;
      port_pad <= '0;
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe <= 1'b0;
    end else begin
      cpu_reset <= (next_state == ST_RESET); // R17
      osc_drive_en <= (next_state != ST_SLEEP); // R01
      // Frozen in sleep; released and tri-stated during reset
      if (state == ST_RESET) begin
        port_pad <= '0;
      end else if (state != ST_SLEEP) begin
        port_pad <= port_drive; // R02
      end
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe <= 1'b0; // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence seq_sleep_entry;
    state == ST_RUN && next_state == ST_SLEEP;
  endsequence
  sequence seq_wake(rcsw_cause_t c);
    state == ST_SLEEP && cause == c;
  endsequence
  sequence seq_core_held;
    cpu_reset [*8];
  endsequence

  AST_SLEEP_ENTRY: assert property (seq_sleep_entry |=> // R01
    flags.time_out_flag && !flags.power_down_flag && !osc_drive_en &&
    wdt_cnt == 32'h0 && state == ST_SLEEP)
    else $error("sleep entry did not update flags or oscillator");
  AST_PAD_HOLD: assert property (state == ST_SLEEP |=> // R02
    port_pad == $past(port_pad))
    else $error("pad drive changed during sleep");
  AST_PIN_NOT_DRIVEN: assert property (cause == CAUSE_WDT |=> // R03
    !external_reset_pin_oe [*2])
    else $error("watchdog reset drove the reset pin");
  AST_WAKE_RESET: assert property (state == ST_SLEEP && // R04
    (ext_assert || wdt_expire || pin_change || cmp_change) |=>
    state == ST_RESET && cpu_reset && osc_drive_en)
    else $error("wake event did not reset the device");
  AST_WDT_SLEEP: assert property (seq_wake(CAUSE_WDT) |=> // R12
    flags == '0 ##1 cpu_reset)
    else $error("watchdog wake flags wrong");
  AST_WDT_RUN: assert property (state == ST_RUN && // R13
    cause == CAUSE_WDT |=> !flags.time_out_flag && !flags.pin_wake_flag &&
    !flags.comparator_wake_flag &&
    flags.power_down_flag == $past(flags.power_down_flag))
    else $error("watchdog run reset flags wrong");
  AST_EXT_SLEEP: assert property (seq_wake(CAUSE_EXT) |=> // R14
    flags == rcsw_flags_t'{1'b0, 1'b0, 1'b1, 1'b0})
    else $error("pin wake flags wrong");
  AST_PIN_WAKE: assert property (seq_wake(CAUSE_PIN) |=> // R15
    flags == rcsw_flags_t'{1'b1, 1'b0, 1'b1, 1'b0})
    else $error("pin change wake flags wrong");
  AST_CMP_WAKE: assert property (seq_wake(CAUSE_CMP) |=> // R07
    flags == rcsw_flags_t'{1'b0, 1'b1, 1'b1, 1'b0})
    else $error("comparator wake flags wrong");
  AST_PORT_SNAP: assert property (reg_rd && reg_addr == OFS_PORT |=> // R09
    pin_snap == $past(pins_s))
    else $error("port snapshot not taken");
  AST_CMP_SNAP: assert property (reg_rd && reg_addr == OFS_CMP |=> // R10
    cmp_snap == $past(cmp_s))
    else $error("comparator snapshot not taken");
  AST_WDT_CLEAR: assert property (state == ST_SLEEP && // R11
    cause != CAUSE_NONE |=> wdt_cnt == 32'h0)
    else $error("watchdog not cleared on wake");
  AST_EXT_RUN: assert property (state == ST_RUN && // R16
    cause == CAUSE_EXT |=> $stable(flags.time_out_flag) &&
    $stable(flags.power_down_flag) && !flags.pin_wake_flag)
    else $error("pin reset changed kept flags");
  AST_DRT_HOLD: assert property (seq_wake(CAUSE_WDT) |=> // R17
    seq_core_held ##[1:120] !cpu_reset || ext_assert)
    else $error("reset timer did not hold and release the core");

endmodule : rcsw_top

// ==== verif/rcsw_pin_model.sv ====
// Outside-world model: reset button, monitored pins and comparators
`timescale 1ns/1ps
module rcsw_pin_model
  import rcsw_pkg::*;
(
  // Requests from the bench
  input wire logic [PIN_W-1:0] req_pins,
  input wire logic [CMP_W-1:0] req_cmp,
  input wire logic req_ext_low,
  // Block's own drive of the reset pin
  input wire logic external_reset_pin_out,
  input wire logic external_reset_pin_oe,
  // Levels seen by the block
  output logic external_reset_pin_n,
  output logic [PIN_W-1:0] mon_pins,
  output logic comparator_one_output,
  output logic comparator_two_output
);
  //////////////////////////////////////////////////////////////////////////
  // Pins and comparators are plain level sources held by the bench
  assign mon_pins = req_pins;
  assign comparator_one_output = req_cmp[0];
  assign comparator_two_output = req_cmp[1];
  // Pull-up on the reset pin: low only if the button or the block pulls it
  assign external_reset_pin_n = ~(req_ext_low |
    (external_reset_pin_oe & ~external_reset_pin_out));
endmodule : rcsw_pin_model

// ==== verif/rcsw_top_tb_top.sv ====
// Self-checking bench for the sleep, wake-up and reset-cause block
`timescale 1ns/1ps
module rcsw_top_tb_top
  import rcsw_pkg::*;
;
  localparam int BOUND = 1000;
  logic sys_clk, srst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd, ex;
  logic external_reset_pin_n, comparator_one_output, comparator_two_output;
  logic external_reset_pin_out, external_reset_pin_oe, req_ext_low;
  logic [PIN_W-1:0] mon_pins, req_pins;
  logic [CMP_W-1:0] req_cmp;
  rcsw_pad_t port_drive, port_pad;
  logic cpu_reset, osc_drive_en, irq;
  int fail_count, n_compared;

  // Short counts keep the run small
  rcsw_top #(.WDT_CYCLES_P(200), .DRT_POR_P(20)) rcsw_top_i (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_reset_pin_n(external_reset_pin_n),
    .mon_pins(mon_pins), .comparator_one_output(comparator_one_output),
    .comparator_two_output(comparator_two_output),
    .external_reset_pin_out(external_reset_pin_out),
    .external_reset_pin_oe(external_reset_pin_oe),
    .port_drive(port_drive), .port_pad(port_pad), .cpu_reset(cpu_reset),
    .osc_drive_en(osc_drive_en), .irq(irq));

  rcsw_pin_model rcsw_pin_model_i (
    .req_pins(req_pins), .req_cmp(req_cmp), .req_ext_low(req_ext_low),
    .external_reset_pin_out(external_reset_pin_out),
    .external_reset_pin_oe(external_reset_pin_oe),
    .external_reset_pin_n(external_reset_pin_n), .mon_pins(mon_pins),
    .comparator_one_output(comparator_one_output),
    .comparator_two_output(comparator_two_output));

  //////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Verdict, one place for every exit
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] flg(bit pw, bit cw, bit to, bit pd);
    logic [7:0] f;
    f = 8'h00;
    f[FLAG_PIN_WAKE] = pw;
    f[FLAG_CMP_WAKE] = cw;
    f[FLAG_TIME_OUT] = to;
    f[FLAG_POWER_DOWN] = pd;
    return f;
  endfunction : flg

  // One-cycle strobes; an idle edge between accesses avoids double drives
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  // Data stand only in the cycle after the taking edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    reg_read(a, rd);
    check(rd, exp);
  endtask : read_check

  // Bounded wait on the core reset; a hang ends the run
  task automatic wait_cpu(input logic lvl);
    for (int i = 0; i < BOUND && cpu_reset !== lvl; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (cpu_reset !== lvl) begin
      fail_count++;
      $display("MISMATCH at %0t: cpu_reset %h expected %h", $time,
               cpu_reset, lvl);
      stop_test();
    end
  endtask : wait_cpu

  task automatic wake_check(input logic [7:0] exp);
    wait_cpu(1'h1);
    check({6'h00, external_reset_pin_out, external_reset_pin_oe}, 8'h00);
    wait_cpu(1'h0);
    read_check(OFS_FLAGS, exp);
  endtask : wake_check

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_power_up;
    wait_cpu(1'h0);
    read_check(OFS_FLAGS, flg(0, 0, 1, 1));
    read_check(OFS_CTRL, 8'h03);
    read_check(OFS_INT_MASK, 8'h00);
    read_check(8'h1c, 8'h00);
  endtask : t_power_up

  // Default control leaves the watchdog running while awake
  task automatic t_wdt_run;
    wake_check(flg(0, 0, 0, 1));
  endtask : t_wdt_run

  task automatic t_pin_wake;
    reg_write(OFS_CTRL, 8'h04);
    @(posedge sys_clk);
    port_drive <= 8'ha5;
    reg_read(OFS_INT_STAT, rd);
    read_check(OFS_PORT, 8'h00);
    reg_write(OFS_CMD, 8'h01);
    @(posedge sys_clk);
    #1 check({7'h00, osc_drive_en}, 8'h00);
    read_check(OFS_FLAGS, flg(0, 0, 1, 0));
    @(posedge sys_clk);
    port_drive <= 8'h5a;
    repeat (3) @(posedge sys_clk);
    #1 check(port_pad, 8'ha5);
    @(posedge sys_clk);
    req_pins <= 4'h2;
    wake_check(flg(1, 0, 1, 0));
    ex = 8'h00;
    ex[INT_WAKE] = 1'h1;
    ex[INT_SLEEP] = 1'h1;
    reg_write(OFS_INT_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 check({7'h00, irq}, 8'h01);
    read_check(OFS_INT_STAT, ex);
    repeat (2) @(posedge sys_clk);
    #1 check({7'h00, irq}, 8'h00);
  endtask : t_pin_wake

  task automatic t_ext_run;
    reg_write(OFS_CTRL, 8'h02);
    @(posedge sys_clk);
    req_ext_low <= 1'h1;
    wait_cpu(1'h1);
    @(posedge sys_clk);
    req_ext_low <= 1'h0;
    wait_cpu(1'h0);
    read_check(OFS_FLAGS, flg(0, 0, 1, 0));
  endtask : t_ext_run

  task automatic t_cmp_wake;
    reg_write(OFS_CTRL, 8'h08);
    read_check(OFS_CMP, 8'h00);
    reg_write(OFS_CMD, 8'h01);
    @(posedge sys_clk);
    req_cmp <= 2'h2;
    wake_check(flg(0, 1, 1, 0));
  endtask : t_cmp_wake

  // Stale pin and comparator levels must not wake with their enables off
  task automatic t_ext_wake;
    reg_write(OFS_CTRL, 8'h02);
    reg_write(OFS_CMD, 8'h01);
    repeat (8) @(posedge sys_clk);
    #1 check({7'h00, cpu_reset}, 8'h00);
    @(posedge sys_clk);
    req_ext_low <= 1'h1;
    wait_cpu(1'h1);
    @(posedge sys_clk);
    req_ext_low <= 1'h0;
    wait_cpu(1'h0);
    read_check(OFS_FLAGS, flg(0, 0, 1, 0));
  endtask : t_ext_wake

  task automatic t_wdt_wake;
    reg_write(OFS_CTRL, 8'h01);
    reg_write(OFS_CMD, 8'h01);
    wait_cpu(1'h1);
    repeat (50) @(posedge sys_clk);
    #1 check({7'h00, cpu_reset}, 8'h01);
    wake_check(flg(0, 0, 0, 0));
  endtask : t_wdt_wake

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    srst = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    req_pins = 4'h0;
    req_cmp = 2'h0;
    req_ext_low = 1'h0;
    port_drive = 8'h00;
    repeat (8) @(posedge sys_clk);
    srst <= 1'h0;
    t_power_up();
    t_wdt_run();
    t_pin_wake();
    t_ext_run();
    t_cmp_wake();
    t_ext_wake();
    t_wdt_wake();
    stop_test();
  end
endmodule : rcsw_top_tb_top
